/* src/spc_pkg.sv */
package spc_pkg;

   // bus geometry
   localparam int unsigned DATA_W = 32;
   localparam int unsigned OFFS_W = 8;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PULLUP = 8'h04;
   localparam logic [7:0] ADDR_EINT = 8'h08;
   localparam logic [7:0] ADDR_ANALOG = 8'h0C;
   localparam logic [7:0] ADDR_OSC = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;

   // standby_control_reg fields
   localparam int unsigned CTRL_HOLD_BIT = 0;
   localparam int unsigned CTRL_MODE_LSB = 1;
   localparam int unsigned CTRL_RSTPIN_BIT = 3;

   // oscillator use fields
   localparam int unsigned OSC_MAIN_BIT = 0;
   localparam int unsigned OSC_SUB_BIT = 1;

   // status field positions (port width up to 8)
   localparam int unsigned STAT_OE_LSB = 0;
   localparam int unsigned STAT_IE_LSB = 8;
   localparam int unsigned STAT_MODE_LSB = 16;
   localparam int unsigned STAT_RSTREQ_BIT = 18;

   // reset values
   localparam logic RST_HOLD = 1'b0;
   localparam logic RST_RSTPIN = 1'b1;
   localparam logic RST_OSC = 1'b0;

   // ahb-lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // operating modes, gray along run-sleep-stop-watch
   typedef enum logic [1:0] {
      SPC_RUN = 2'h0,
      SPC_SLEEP = 2'h1,
      SPC_STOP = 2'h3,
      SPC_WATCH = 2'h2
   } spc_mode_t;

   // mode context shared by every pin
   typedef struct packed {
      logic standby;
      logic hold_sel;
   } spc_ctx_t;

   // per-pin configuration
   typedef struct packed {
      logic pu_en;
      logic eint_en;
      logic analog;
      logic osc;
      logic rst;
   } spc_cfg_t;

   // per-pin port side data
   typedef struct packed {
      logic out;
      logic dir;
      logic in;
   } spc_port_t;

   // per-pin pad and core results
   typedef struct packed {
      logic out;
      logic oe;
      logic pu;
      logic ie;
      logic core;
      logic eint;
   } spc_pad_t;

endpackage

/* src/spc_pin_cell.sv */
`timescale 1ns/1ps

// one port pin: pad drive, pull-up, input gate and interrupt path
module spc_pin_cell #(
   parameter logic PU_CAP = 1'b1,
   parameter logic EINT_CAP = 1'b0,
   parameter logic ANA_CAP = 1'b0
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control
   input wire spc_pkg::spc_ctx_t ctx,
   input wire spc_pkg::spc_cfg_t cfg,
   input wire spc_pkg::spc_port_t port,
   // result
   output spc_pkg::spc_pad_t pad
);

   typedef struct packed {
      spc_pkg::spc_pad_t pad;
   } st_t;

   st_t s_q;
   st_t s_d;

   // next pad state from mode and configuration
   always_comb begin
      s_d = s_q;
      s_d.pad.pu = PU_CAP & cfg.pu_en;
      s_d.pad.core = 1'b0;
      s_d.pad.eint = 1'b0;
      if (cfg.rst) begin
         s_d.pad.oe = 1'b0;
         s_d.pad.ie = 1'b1;
         s_d.pad.pu = 1'b0;
      end else if (cfg.osc) begin
         s_d.pad.oe = 1'b0;
         s_d.pad.ie = 1'b0;
         s_d.pad.pu = 1'b0;
      end else if (!ctx.standby) begin
         s_d.pad.out = port.out;
         s_d.pad.oe = port.dir;
         s_d.pad.ie = ~(ANA_CAP & cfg.analog);
         s_d.pad.core = port.in & s_d.pad.ie;
         s_d.pad.eint = port.in & s_d.pad.ie & EINT_CAP & cfg.eint_en;
      end else begin
         if (ctx.hold_sel) begin
            s_d.pad.oe = 1'b0;
         end
         s_d.pad.ie = EINT_CAP & cfg.eint_en;
         s_d.pad.eint = port.in & s_d.pad.ie;
         s_d.pad.pu = PU_CAP & cfg.pu_en;
      end
   end

   // reset: hi-z, input gate on unless analog
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q.pad.out <= 1'b0;
         s_q.pad.oe <= 1'b0;
         s_q.pad.pu <= 1'b0;
         s_q.pad.ie <= ~ANA_CAP;
         s_q.pad.core <= 1'b0;
         s_q.pad.eint <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pad = s_q.pad;

endmodule

/* src/spc_pin_ctrl.sv */
`timescale 1ns/1ps

// Operation
// - standby_pin_hold_select in standby_control_reg picks hold or float in stop/watch
// - stop/watch, select clear: pins keep last drive, input gate blocked
// - stop/watch, select set: drivers off to hi-z, input gate blocked
// - blocked input never reaches internal logic
// - interrupt pins pass level to detector when their interrupt is enabled
// - pull-up setting stays applied on capable pins while floating
// - oscillator pins float in stop/watch; as ports they follow hold/float
// - reset_capable_port_pin acts as reset input in every mode
// - during reset pins are hi-z, input buffer on, nothing acts on it
// - enabled input means active buffer; output pins behave as other ports
// - analog-capable pins in reset are hi-z with input gate blocked
module spc_pin_ctrl #(
   parameter int unsigned N_PIN = 8,
   parameter logic [7:0] PU_CAP = 8'hF8,
   parameter logic [7:0] EINT_CAP = 8'hE0,
   parameter logic [7:0] ANA_CAP = 8'hC0,
   parameter int unsigned MAIN_IN_IDX = 0,
   parameter int unsigned MAIN_OUT_IDX = 1,
   parameter int unsigned RST_IDX = 2,
   parameter int unsigned SUB_IN_IDX = 3,
   parameter int unsigned SUB_OUT_IDX = 4
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // port and peripheral side
   input wire logic [N_PIN-1:0] port_out,
   input wire logic [N_PIN-1:0] port_dir,
   output logic [N_PIN-1:0] core_in,
   output logic [N_PIN-1:0] eint_in,
   // wake request from the interrupt logic
   input wire logic wake,
   // pads
   input wire logic [N_PIN-1:0] pad_in,
   output logic [N_PIN-1:0] pad_out,
   output logic [N_PIN-1:0] pad_oe,
   output logic [N_PIN-1:0] pad_pu,
   output logic [N_PIN-1:0] pad_ie,
   // mode and reset status
   output logic [1:0] mode,
   output logic reset_req_n
);

   // register state of the block, apart from the pad flops held in the pin cells
   typedef struct packed {
      spc_pkg::spc_mode_t mode;
      logic hold_sel;
      logic rst_pin_en;
      logic [N_PIN-1:0] pu_en;
      logic [N_PIN-1:0] eint_en;
      logic [N_PIN-1:0] ana_sel;
      logic osc_main;
      logic osc_sub;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic rdy;
      logic rst_req_n;
   } st_t;

   st_t s_q;
   st_t s_d;

   logic [N_PIN-1:0] oe_w;
   logic [N_PIN-1:0] ie_w;
   logic [N_PIN-1:0] out_w;
   logic [N_PIN-1:0] pu_w;
   logic [N_PIN-1:0] core_w;
   logic [N_PIN-1:0] eint_w;
   logic addr_ok;
   spc_pkg::spc_ctx_t ctx;

   // word read of the register map from a given state
   function automatic logic [31:0] reg_read(
      input st_t s,
      input logic [7:0] a,
      input logic [N_PIN-1:0] oe,
      input logic [N_PIN-1:0] ie
   );
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         spc_pkg::ADDR_CTRL: begin
            r[spc_pkg::CTRL_HOLD_BIT] = s.hold_sel;
            r[spc_pkg::CTRL_MODE_LSB +: 2] = s.mode;
            r[spc_pkg::CTRL_RSTPIN_BIT] = s.rst_pin_en;
         end
         spc_pkg::ADDR_PULLUP: begin
            r[N_PIN-1:0] = s.pu_en;
         end
         spc_pkg::ADDR_EINT: begin
            r[N_PIN-1:0] = s.eint_en;
         end
         spc_pkg::ADDR_ANALOG: begin
            r[N_PIN-1:0] = s.ana_sel;
         end
         spc_pkg::ADDR_OSC: begin
            r[spc_pkg::OSC_MAIN_BIT] = s.osc_main;
            r[spc_pkg::OSC_SUB_BIT] = s.osc_sub;
         end
         spc_pkg::ADDR_STAT: begin
            r[spc_pkg::STAT_OE_LSB +: N_PIN] = oe;
            r[spc_pkg::STAT_IE_LSB +: N_PIN] = ie;
            r[spc_pkg::STAT_MODE_LSB +: 2] = s.mode;
            r[spc_pkg::STAT_RSTREQ_BIT] = s.rst_req_n;
         end
         default: begin
            r = 32'h0000_0000;
         end
      endcase
      return r;
   endfunction

   // only aligned word offsets inside the map decode
   assign addr_ok = (haddr[1:0] == 2'h0);

   // stop and watch are the only modes that touch the pins
   // select feeds every pin
   assign ctx = '{standby: (s_q.mode == spc_pkg::SPC_STOP) || (s_q.mode == spc_pkg::SPC_WATCH),
                  hold_sel: s_q.hold_sel};

   // bus slave, mode sequencer and reset pin sampling
   always_comb begin
      logic take;
      logic [31:0] w;
      spc_pkg::spc_mode_t req;
      take = 1'b0;
      w = hwdata;
      req = spc_pkg::SPC_RUN;
      s_d = s_q;
      s_d.rdy = 1'b1;
      s_d.wr_pend = 1'b0;
      // data phase of a write lands here, one cycle after its address
      if (s_q.wr_pend) begin
         unique case (s_q.wr_addr)
            spc_pkg::ADDR_CTRL: begin
               s_d.hold_sel = w[spc_pkg::CTRL_HOLD_BIT];
               s_d.rst_pin_en = w[spc_pkg::CTRL_RSTPIN_BIT];
               req = spc_pkg::spc_mode_t'(w[spc_pkg::CTRL_MODE_LSB +: 2]);
            end
            spc_pkg::ADDR_PULLUP: begin
               s_d.pu_en = w[N_PIN-1:0];
            end
            spc_pkg::ADDR_EINT: begin
               s_d.eint_en = w[N_PIN-1:0];
            end
            spc_pkg::ADDR_ANALOG: begin
               s_d.ana_sel = w[N_PIN-1:0];
            end
            spc_pkg::ADDR_OSC: begin
               s_d.osc_main = w[spc_pkg::OSC_MAIN_BIT];
               s_d.osc_sub = w[spc_pkg::OSC_SUB_BIT];
            end
            default: begin
               take = 1'b0;
            end
         endcase
      end
      // mode sequencer: software enters a standby mode, a wake returns to run
      unique case (s_q.mode)
         spc_pkg::SPC_RUN: begin
            s_d.mode = req;
         end
         spc_pkg::SPC_SLEEP, spc_pkg::SPC_STOP, spc_pkg::SPC_WATCH: begin
            if (wake) begin
               s_d.mode = spc_pkg::SPC_RUN;
            end
         end
      endcase
      // address phase; reads see a write still in its data phase
      take = hsel & hready & (htrans == spc_pkg::HTRANS_NONSEQ) & addr_ok;
      if (take && hwrite) begin
         s_d.wr_pend = 1'b1;
         s_d.wr_addr = haddr[7:0];
      end
      if (take && !hwrite) begin
         s_d.rdata = reg_read(s_d, haddr[7:0], oe_w, ie_w);
      end else begin
         s_d.rdata = 32'h0000_0000;
      end
      // reset input kept live in all modes
      s_d.rst_req_n = ~s_q.rst_pin_en | pad_in[RST_IDX];
   end

   // single state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q.mode <= spc_pkg::SPC_RUN;
         s_q.hold_sel <= spc_pkg::RST_HOLD;
         s_q.rst_pin_en <= spc_pkg::RST_RSTPIN;
         s_q.pu_en <= '0;
         s_q.eint_en <= '0;
         s_q.ana_sel <= '0;
         s_q.osc_main <= spc_pkg::RST_OSC;
         s_q.osc_sub <= spc_pkg::RST_OSC;
         s_q.wr_pend <= 1'b0;
         s_q.wr_addr <= 8'h00;
         s_q.rdata <= 32'h0000_0000;
         s_q.rdy <= 1'b1;
         s_q.rst_req_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // one cell per pin; capability masks fix each pin's options
   for (genvar i = 0; i < N_PIN; i++) begin : g_pin
      spc_pkg::spc_cfg_t cfg;
      spc_pkg::spc_port_t prt;
      spc_pkg::spc_pad_t pad;
      logic osc_use;
      // oscillator use claims the pin, port use otherwise
      assign osc_use = (((i == MAIN_IN_IDX) || (i == MAIN_OUT_IDX)) && s_q.osc_main)
                    || (((i == SUB_IN_IDX) || (i == SUB_OUT_IDX)) && s_q.osc_sub);
      // one driver per struct: the whole configuration in one pattern
      assign cfg = '{pu_en: s_q.pu_en[i], eint_en: s_q.eint_en[i], analog: s_q.ana_sel[i],
                     osc: osc_use, rst: (i == RST_IDX) && s_q.rst_pin_en};
      assign prt = '{out: port_out[i], dir: port_dir[i], in: pad_in[i]};
      spc_pin_cell #(
         .PU_CAP(PU_CAP[i]),
         .EINT_CAP(EINT_CAP[i]),
         .ANA_CAP(ANA_CAP[i])
      ) u_cell (
         .hclk(hclk),
         .hresetn(hresetn),
         .ctx(ctx),
         .cfg(cfg),
         .port(prt),
         .pad(pad)
      );
      assign out_w[i] = pad.out;
      assign oe_w[i] = pad.oe;
      assign pu_w[i] = pad.pu;
      assign ie_w[i] = pad.ie;
      assign core_w[i] = pad.core;
      assign eint_w[i] = pad.eint;
   end

   // outputs straight from a cell or state flop, except hresp, which is tied to okay
   assign pad_out = out_w;
   assign pad_oe = oe_w;
   assign pad_pu = pu_w;
   assign pad_ie = ie_w;
   assign core_in = core_w;
   assign eint_in = eint_w;
   assign mode = s_q.mode;
   assign reset_req_n = s_q.rst_req_n;
   assign hrdata = s_q.rdata;
   assign hreadyout = s_q.rdy;
   // errors are never signalled; unmapped words read zero
   assign hresp = spc_pkg::HRESP_OKAY;

endmodule

/* sim/spc_board.sv */
`timescale 1ns/1ps

// board side of the pins: external drivers, pull-ups and undriven lines
module spc_board (
   // clock
   input wire logic hclk,
   // device pads
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pu,
   // board drivers
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_v,
   output logic [7:0] pad_in
);
   logic flt_q;

   // an undriven line has no stable level, so it keeps changing
   initial flt_q = 1'b0;
   always @(posedge hclk) flt_q <= ~flt_q;

   // resolve each line: device drive, board drive, pull-up, else floating
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else if (ext_en[i]) pad_in[i] = ext_v[i];
         else if (pad_pu[i]) pad_in[i] = 1'b1;
         else pad_in[i] = flt_q ^ i[0];
      end
   end
endmodule

/* sim/spc_pin_ctrl_checker.sv */
`timescale 1ns/1ps

// watches bus and pins of the pin-state block
module spc_pin_ctrl_checker #(
   parameter logic [7:0] EINT_CAP = 8'hE0,
   parameter logic [7:0] ANA_CAP = 8'hC0
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // pins
   input wire logic [7:0] pad_in,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pu,
   input wire logic [7:0] pad_ie,
   input wire logic [7:0] core_in,
   input wire logic [1:0] mode,
   input wire logic reset_req_n
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_q;

   // a read address phase was taken on the last edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) rd_q <= 1'b0;
      else rd_q <= hsel && hready && htrans == 2'h2 && !hwrite;
   end

   // stop or watch held over consecutive edges
   sequence s_stby2; mode[1] [*2]; endsequence
   sequence s_stby3; mode[1] [*3]; endsequence

   property p_rst_pads; $rose(hresetn) |-> pad_oe == 8'h00 && pad_ie == ~ANA_CAP; endproperty
   property p_okay; hreadyout && !hresp; endproperty
   property p_rdata; !rd_q |-> hrdata == 32'h0; endproperty
   property p_core_blk; s_stby2 |-> core_in == 8'h00; endproperty
   property p_freeze; s_stby3 |-> $stable(pad_out) && $stable(pad_oe); endproperty
   property p_pu_keep; s_stby3 |-> $stable(pad_pu); endproperty
   property p_ie_eint; s_stby2 |-> (pad_ie & ~(EINT_CAP | 8'h04)) == 8'h00; endproperty
   property p_rst_pin; !reset_req_n |-> !$past(pad_in[2]); endproperty

   a_rst_pads: assert property (p_rst_pads) else $error("pads left reset state");
   a_okay: assert property (p_okay) else $error("bus not ready or not okay");
   a_rdata: assert property (p_rdata) else $error("read data outside data phase");
   a_core_blk: assert property (p_core_blk) else $error("input reached core in standby");
   a_freeze: assert property (p_freeze) else $error("pad drive moved in standby");
   a_pu_keep: assert property (p_pu_keep) else $error("pull-up moved in standby");
   a_ie_eint: assert property (p_ie_eint) else $error("input gate open in standby");
   a_rst_pin: assert property (p_rst_pin) else $error("reset request without low pin");
endmodule

bind spc_pin_ctrl spc_pin_ctrl_checker #(.EINT_CAP(EINT_CAP), .ANA_CAP(ANA_CAP)) chk_u (
   .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
   .pad_in, .pad_out, .pad_oe, .pad_pu, .pad_ie, .core_in, .mode, .reset_req_n);

/* sim/spc_pin_ctrl_tb.sv */
`timescale 1ns/1ps

// self-checking bench for the pin-state block
module spc_pin_ctrl_tb;
   logic hclk, hresetn, hsel, hwrite, wake, hreadyout, hresp, reset_req_n;
   logic [1:0] htrans, mode;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [7:0] port_out, port_dir, core_in, eint_in, pad_in, pad_out, pad_oe, pad_pu, pad_ie;
   logic [7:0] ext_en, ext_v;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;

   spc_pin_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .port_out, .port_dir, .core_in,
      .eint_in, .wake, .pad_in, .pad_out, .pad_oe, .pad_pu, .pad_ie, .mode, .reset_req_n);
   spc_board brd_u (.hclk, .pad_out, .pad_oe, .pad_pu, .ext_en, .ext_v, .pad_in);

   // clock
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   // hang guard, far beyond the hundred or so cycles the run needs
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   // one single transfer; each phase stands until hready is seen high at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= spc_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // mode lands on the edge that ends the data phase, pads one edge later
   task automatic enter(input logic [7:0] v);
      bus(1'b1, spc_pkg::ADDR_CTRL, {24'h0, v});
      repeat (3) @(negedge hclk);
   endtask

   task automatic wakeup();
      @(posedge hclk);
      wake <= 1'b1;
      @(posedge hclk);
      wake <= 1'b0;
      repeat (3) @(negedge hclk);
   endtask

   task automatic t_regs();
      bus(1'b0, spc_pkg::ADDR_CTRL, 0);
      chk("ctrl", 32'h8, rd);
      bus(1'b1, spc_pkg::ADDR_CTRL, 32'h9);
      bus(1'b0, spc_pkg::ADDR_CTRL, 0);
      chk("ctrl", 32'h9, rd);
      bus(1'b1, 8'h20, 32'h5A);
      bus(1'b0, 8'h20, 0);
      chk("unmapped", 32'h0, rd);
   endtask

   // run then sleep: pins behave alike in both
   task automatic t_run_sleep();
      for (int m = 0; m < 2; m++) begin
         enter(m ? 8'h0A : 8'h08);
         chk("oe", 8'hFB, pad_oe);
         chk("out", 8'hA1, pad_out & 8'hFB);
         chk("core", 8'hA1, core_in & 8'hFB);
      end
      wakeup();
   endtask

   task automatic t_stop_hold();
      enter(8'h0E);
      @(posedge hclk);
      port_out <= 8'h5A;
      repeat (2) @(negedge hclk);
      chk("mode", 2'h3, mode);
      chk("oe", 8'hFB, pad_oe);
      chk("out", 8'hA1, pad_out & 8'hFB);
      chk("core", 8'h00, core_in);
      chk("ie", 8'h04, pad_ie);
      wakeup();
      chk("out", 8'h5A, pad_out & 8'hFB);
   endtask

   task automatic t_watch_float();
      bus(1'b1, spc_pkg::ADDR_PULLUP, 32'hFF);
      bus(1'b1, spc_pkg::ADDR_EINT, 32'h20);
      enter(8'h0D);
      chk("oe", 8'h00, pad_oe);
      chk("pu", 8'hF8, pad_pu);
      chk("ie", 8'h24, pad_ie);
      @(posedge hclk);
      ext_en <= 8'h24;
      ext_v <= 8'h00;
      repeat (2) @(negedge hclk);
      chk("eint", 8'h00, eint_in & 8'h20);
      chk("rreq", 1'b0, reset_req_n);
      chk("core", 8'h00, core_in);
      @(posedge hclk);
      ext_en <= 8'h04;
      ext_v <= 8'h04;
      repeat (2) @(negedge hclk);
      chk("eint", 8'h20, eint_in & 8'h20);
      chk("rreq", 1'b1, reset_req_n);
      wakeup();
   endtask

   task automatic t_osc();
      bus(1'b1, spc_pkg::ADDR_OSC, 32'h3);
      repeat (3) @(negedge hclk);
      chk("oe", 8'hE0, pad_oe);
      chk("ie", 8'h00, pad_ie & 8'h1B);
      chk("pu", 8'hE0, pad_pu);
      // analog select closes the digital gate of capable pins; status mirrors the pads
      bus(1'b1, spc_pkg::ADDR_ANALOG, 32'hFF);
      repeat (3) @(negedge hclk);
      chk("ana ie", 8'h00, pad_ie & 8'hC0);
      bus(1'b0, spc_pkg::ADDR_STAT, 0);
      chk("stat", 32'h0004_24E0, rd);
   endtask

   // main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      port_out = 8'hA5;
      port_dir = 8'hFF;
      wake = 1'b0;
      ext_en = 8'h04;
      ext_v = 8'h04;
      repeat (15) @(posedge hclk);
      chk("rst oe", 8'h00, pad_oe);
      chk("rst ie", 8'h3F, pad_ie);
      @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_run_sleep();
      t_stop_hold();
      t_watch_float();
      t_osc();
      summarize();
   end
endmodule
